// ---- hw/pbt_pkg.sv ----
// Contract
// R1 - Power-up pulse initialises the counter only while the disable input is low.
// R2 - Forced init held high keeps the counter in reset; low lets it run.
// R3 - Any reset clears every counter stage synchronously, whatever the count.
// R4 - Any active reset stops the oscillator, so no counting tick occurs.
// R5 - Forced init works whether power-up initialisation is enabled or not.
// R6 - The 16-stage binary counter advances on each counting clock rising edge.
// R7 - Selects 00 picks stage 13, 01 stage 10, 10 stage 8, 11 stage 16.
// R8 - A count of 2 to the n-1 is the true output of stage n.
// R9 - Low select at 0 clocks the ninth stage straight from the oscillator; the code does this only while the high select is 1.
// R10 - During reset the output equals the polarity select level.
// R11 - Recycle mode passes the selected stage continuously to the output.
// R12 - Single-cycle mode clears a latch, counts 2^(n-1), then sets it, flipping output.
// R13 - Single-cycle output then holds; forced init or a mode change restarts it.
// R14 - An external clock may replace the internal oscillator as counting clock.
// R15 - Power-on detector pulse, gated by the disable input, joins forced init.
package pbt_pkg;
	// Counter geometry
	localparam int          STAGES       = 16;
	localparam int          LO_STAGES    = 8;
	// Tap stage numbers
	localparam int          TAP_SEL_00   = 13;
	localparam int          TAP_SEL_01   = 10;
	localparam int          TAP_SEL_10   = 8;
	localparam int          TAP_SEL_11   = 16;
	// Internal oscillator model
	localparam int          REF_FREQ_KHZ = 125000;
	localparam int          OSC_FREQ_KHZ = 100;
	localparam int          OSC_DIV      = REF_FREQ_KHZ / OSC_FREQ_KHZ;
	localparam int          OSC_CNT_W    = 16;
	// Register byte offsets
	localparam logic [11:0] CTRL_OFS     = 12'h000;
	localparam logic [11:0] STAT_OFS     = 12'h004;
	localparam logic [11:0] COUNT_OFS    = 12'h008;
	// Control fields
	localparam int          CTRL_MODE    = 0;
	localparam int          CTRL_POL     = 1;
	localparam int          CTRL_SEL_LO  = 2;
	localparam int          CTRL_SEL_HI  = 3;
	localparam int          CTRL_FINIT   = 4;
	localparam int          CTRL_EXTCLK  = 5;
	localparam int          CTRL_W       = 6;
	localparam logic [5:0]  CTRL_RST     = 6'h00;
	// Status fields
	localparam int          STAT_OUT     = 0;
	localparam int          STAT_LATCH   = 1;
	localparam int          STAT_INRST   = 2;
	localparam int          STAT_EXTCLK  = 3;
endpackage

// ---- hw/pbt_osc.sv ----
`timescale 1ns/1ps
module pbt_osc #(
	parameter int OSC_DIV = pbt_pkg::OSC_DIV
) (
	input  wire logic i_ref_clk,
	input  wire logic i_rst,
	input  wire logic i_ce,
	input  wire logic i_stop,
	input  wire logic i_ext_sel,
	input  wire logic i_ext_clk,
	output logic      o_tick
);
	localparam logic [pbt_pkg::OSC_CNT_W-1:0] DIV_LAST = pbt_pkg::OSC_CNT_W'(OSC_DIV - 1);

	logic [pbt_pkg::OSC_CNT_W-1:0] div_reg;
	logic                          ext_prev_reg;
	logic                          tick_reg;

	// Internal oscillator divider, held cleared while stopped
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst || (i_ce && (i_stop || i_ext_sel)))
			div_reg <= '0; // [R4]
		else if (i_ce)
			div_reg <= (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1;
	end

	// External clock edge history, forgotten during reset
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst || (i_ce && i_stop))
			ext_prev_reg <= 1'b1;
		else if (i_ce)
			ext_prev_reg <= i_ext_clk;
	end

	// One tick per oscillator period or external rising edge
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			tick_reg <= 1'b0;
		else if (i_ce)
		begin
			if (i_stop)
				tick_reg <= 1'b0; // [R4]
			else if (i_ext_sel)
				tick_reg <= i_ext_clk && !ext_prev_reg; // [R14]
			else
				tick_reg <= (div_reg == DIV_LAST);
		end
	end

	assign o_tick = tick_reg && i_ce && !i_stop;
endmodule

// ---- hw/pbt_timer.sv ----
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module pbt_timer #(
	parameter int OSC_DIV   = pbt_pkg::OSC_DIV,
	parameter int STAGES    = pbt_pkg::STAGES,
	parameter int LO_STAGES = pbt_pkg::LO_STAGES
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire logic        i_por_pulse,
	input  wire logic        i_power_on_init_off,
	input  wire logic        i_ext_clk,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic             o_timer_out
);
	localparam int HI_STAGES = STAGES - LO_STAGES;

	// Stage number picked by the two period selects
	function automatic int tap_stage(input logic sel_hi, input logic sel_lo);
		int n;
		n = pbt_pkg::TAP_SEL_00;
		unique case ({sel_hi, sel_lo})
			2'b00: n = pbt_pkg::TAP_SEL_00;
			2'b01: n = pbt_pkg::TAP_SEL_01;
			2'b10: n = pbt_pkg::TAP_SEL_10;
			2'b11: n = pbt_pkg::TAP_SEL_11;
		endcase
		return n;
	endfunction

	// Address match helper for the register decode
	function automatic logic ofs_hit(input logic [11:0] addr, input logic [11:0] ofs);
		return (addr[11:2] == ofs[11:2]);
	endfunction

	// Register and state storage
	logic [pbt_pkg::CTRL_W-1:0] ctrl_reg;
	logic [LO_STAGES-1:0]       cnt_lo_reg;
	logic [HI_STAGES-1:0]       cnt_hi_reg;
	logic                       latch_reg;
	logic                       mode_prev_reg;
	logic                       out_reg;
	logic                       out_next;
	logic [31:0]                prdata_reg;
	logic                       slverr_reg;
	logic                       rvalid_reg;

	// Decoded control fields
	logic                       mode_recycle;
	logic                       pol_high;
	logic                       sel_lo;
	logic                       sel_hi;
	logic                       forced_init;
	logic                       ext_sel;

	// Reset and counting terms
	logic                       por_init;
	logic                       mode_change;
	logic                       in_reset;
	logic                       tick;
	logic                       bypass;
	logic                       lo_carry;
	logic                       hi_clk;
	logic [STAGES-1:0]          count;
	logic                       tap;

	// Bus terms
	logic                       bus_setup;
	logic                       bus_done;
	logic                       wr_ctrl;
	logic [31:0]                rd_data;
	logic                       rd_err;

	assign mode_recycle = ctrl_reg[pbt_pkg::CTRL_MODE];
	assign pol_high     = ctrl_reg[pbt_pkg::CTRL_POL];
	assign sel_lo       = ctrl_reg[pbt_pkg::CTRL_SEL_LO];
	assign sel_hi       = ctrl_reg[pbt_pkg::CTRL_SEL_HI];
	assign forced_init  = ctrl_reg[pbt_pkg::CTRL_FINIT];
	assign ext_sel      = ctrl_reg[pbt_pkg::CTRL_EXTCLK];

	// Power-up pulse only counts while initialisation is enabled
	assign por_init    = i_por_pulse && !i_power_on_init_off; // [R1] [R15]

	// A mode level change restarts a single cycle
	assign mode_change = (mode_recycle != mode_prev_reg); // [R13]

	// Forced init acts on its own, ORed with the gated power-up pulse
	assign in_reset    = forced_init || por_init || mode_change; // [R2] [R5] [R15]

	// Counting clock source, stopped while any reset is active
	pbt_osc #(
		.OSC_DIV (OSC_DIV)
	) u_osc (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_ce      (i_ce),
		.i_stop    (in_reset),
		.i_ext_sel (ext_sel),
		.i_ext_clk (i_ext_clk),
		.o_tick    (tick)
	);

	// Upper chain fed straight from the oscillator for the stage 8 tap
	assign bypass   = sel_hi && !sel_lo; // [R9]
	assign lo_carry = tick && (cnt_lo_reg == {LO_STAGES{1'b1}});
	assign hi_clk   = bypass ? tick : lo_carry; // [R9]
	assign count    = {cnt_hi_reg, cnt_lo_reg};

	// Tap picks the true output of the selected stage
	always_comb
	begin
		if (bypass)
			tap = cnt_hi_reg[HI_STAGES-1]; // [R9]
		else
			tap = count[tap_stage(sel_hi, sel_lo) - 1]; // [R7] [R8]
	end

	// Lower eight stages
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			cnt_lo_reg <= '0;
		else if (i_ce)
		begin
			if (in_reset)
				cnt_lo_reg <= '0; // [R3]
			else if (tick && !bypass)
				cnt_lo_reg <= cnt_lo_reg + 1'b1; // [R6]
		end
	end

	// Upper eight stages
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			cnt_hi_reg <= '0;
		else if (i_ce)
		begin
			if (in_reset)
				cnt_hi_reg <= '0; // [R3]
			else if (hi_clk)
				cnt_hi_reg <= cnt_hi_reg + 1'b1; // [R6]
		end
	end

	// Single-cycle latch: cleared by reset, set once the tap first rises
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			latch_reg <= 1'b0;
		else if (i_ce)
		begin
			if (in_reset)
				latch_reg <= 1'b0; // [R12]
			else if (tap)
				latch_reg <= 1'b1; // [R12] [R13]
		end
	end

	// Mode history for change detection
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			mode_prev_reg <= pbt_pkg::CTRL_RST[pbt_pkg::CTRL_MODE];
		else if (i_ce)
			mode_prev_reg <= mode_recycle;
	end

	// Output level selection
	always_comb
	begin
		if (in_reset)
			out_next = pol_high; // [R10]
		else if (mode_recycle)
			out_next = pol_high ^ tap; // [R11]
		else
			out_next = pol_high ^ (latch_reg || tap); // [R12] [R13]
	end

	// Registered timer output
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			out_reg <= pbt_pkg::CTRL_RST[pbt_pkg::CTRL_POL];
		else if (i_ce)
			out_reg <= out_next;
	end

	assign o_timer_out = out_reg;

	// APB phase tracking
	assign bus_setup = i_psel && !i_penable;
	assign bus_done  = i_psel && i_penable && rvalid_reg && i_ce;
	assign wr_ctrl   = bus_done && i_pwrite && ofs_hit(i_paddr, pbt_pkg::CTRL_OFS) && i_pstrb[0];

	// Read mux and unmapped detection
	always_comb
	begin
		rd_data = 32'h0000_0000;
		rd_err  = 1'b0;
		if (ofs_hit(i_paddr, pbt_pkg::CTRL_OFS))
			rd_data[pbt_pkg::CTRL_W-1:0] = ctrl_reg;
		else if (ofs_hit(i_paddr, pbt_pkg::STAT_OFS))
		begin
			rd_data[pbt_pkg::STAT_OUT]    = out_reg;
			rd_data[pbt_pkg::STAT_LATCH]  = latch_reg;
			rd_data[pbt_pkg::STAT_INRST]  = in_reset;
			rd_data[pbt_pkg::STAT_EXTCLK] = ext_sel;
		end
		else if (ofs_hit(i_paddr, pbt_pkg::COUNT_OFS))
			rd_data[STAGES-1:0] = count;
		else
			rd_err = 1'b1;
	end

	// Read data and error captured once, in the first selected cycle of the request
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			prdata_reg <= 32'h0000_0000;
			slverr_reg <= 1'b0;
		end
		else if (i_ce && i_psel && !rvalid_reg)
		begin
			prdata_reg <= i_pwrite ? 32'h0000_0000 : rd_data;
			slverr_reg <= rd_err;
		end
	end

	// Answer becomes ready one cycle after capture
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			rvalid_reg <= 1'b0;
		else if (i_ce)
		begin
			if (!i_psel || bus_done)
				rvalid_reg <= 1'b0;
			else if (bus_setup || i_psel)
				rvalid_reg <= 1'b1;
		end
	end

	// Control register write
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			ctrl_reg <= pbt_pkg::CTRL_RST;
		else if (wr_ctrl)
			ctrl_reg <= i_pwdata[pbt_pkg::CTRL_W-1:0];
	end

	assign o_prdata  = prdata_reg;
	assign o_pready  = i_psel && i_penable && rvalid_reg && i_ce;
	assign o_pslverr = o_pready && slverr_reg;
endmodule

// ---- verif/pbt_timer_chk.sv ----
`timescale 1ns/1ps
module pbt_timer_chk (
	input wire logic        i_ref_clk,
	input wire logic        i_rst,
	input wire logic        i_ce,
	input wire logic        i_por_pulse,
	input wire logic        i_power_on_init_off,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        o_timer_out
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	logic map;
	// Mapped register words
	assign map = (i_paddr[11:2] <= 10'h002);
	property p_rst; disable iff (1'b0) i_rst && i_ce |=> !o_timer_out && !o_pready; endproperty
	a_rst: assert property (p_rst) else $error("out or ready high after reset");
	property p_acc; o_pready |-> i_psel && i_penable; endproperty
	a_acc: assert property (p_acc) else $error("ready outside access");
	property p_first; i_psel && !i_penable && i_ce ##1 i_psel && i_penable && i_ce |-> o_pready; endproperty
	a_first: assert property (p_first) else $error("ready late");
	property p_err; o_pready && !map |-> o_pslverr && o_prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("unmapped not refused");
	property p_ok; o_pready && map |-> !o_pslverr; endproperty
	a_ok: assert property (p_ok) else $error("mapped refused");
	property p_hi; o_pready && !i_pwrite |-> o_prdata[31:16] == 16'h0000; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
	property p_por; (i_por_pulse && !i_power_on_init_off && i_ce) [*3] |-> $stable(o_timer_out); endproperty
	a_por: assert property (p_por) else $error("out moves in reset");
	property p_ce; o_pready |-> i_ce; endproperty
	a_ce: assert property (p_ce) else $error("ready while frozen");
	c_err: cover property (o_pready && o_pslverr);
	c_out: cover property ($rose(o_timer_out));
	c_por: cover property (i_por_pulse && !i_power_on_init_off);
endmodule

// ---- verif/pbt_ext_src.sv ----
`timescale 1ns/1ps
module pbt_ext_src (
	input  wire logic        i_ref_clk,
	input  wire logic        i_go,
	input  wire logic [15:0] i_num,
	output logic             o_ext_clk,
	output logic             o_busy
);
	logic [16:0] left_reg = 17'h0;
	// Burst of pulses, one per two cycles, idle low
	always_ff @(posedge i_ref_clk)
	begin
		if (i_go)
			left_reg <= {i_num, 1'b0};
		else if (left_reg != 17'h0)
			left_reg <= left_reg - 17'h1;
	end
	assign o_ext_clk = left_reg[0];
	assign o_busy    = left_reg != 17'h0;
endmodule

// ---- verif/tb_programmable_binary_timer.sv ----
`timescale 1ns/1ps
module tb_programmable_binary_timer;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        por = 1'b0;
	logic        por_off = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        go = 1'b0;
	logic [15:0] num = 16'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        tout;
	logic        ext;
	logic        busy;
	logic [31:0] q;
	logic        err;
	int          num_errors = 0;
	int          total_checks = 0;
	always #4 clk = ~clk;
	pbt_timer #(.OSC_DIV(2)) i_dut (
		.i_ref_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_por_pulse(por),
		.i_power_on_init_off(por_off), .i_ext_clk(ext), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_timer_out(tout));
	pbt_ext_src i_src (.i_ref_clk(clk), .i_go(go), .i_num(num), .o_ext_clk(ext), .o_busy(busy));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One APB transfer, held until ready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge clk);
	endtask
	// Send n counting edges and let the output settle
	task automatic edges(input int n);
		@(posedge clk);
		go <= 1'b1;
		num <= n[15:0];
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		while (busy === 1'b1)
			@(posedge clk);
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic pulse(input logic off);
		@(posedge clk);
		por_off <= off;
		por <= 1'b1;
		repeat (3) @(posedge clk);
		por <= 1'b0;
	endtask
	task automatic t_regs;
		apb(1'b0, 12'h000, 32'h0);
		chk(q, 32'h0, "ctrl");
		chk(tout, 1'b0, "out");
		apb(1'b0, 12'h00c, 32'h0);
		chk(q, 32'h0, "bad data");
		chk(err, 1'b1, "bad err");
	endtask
	task automatic t_tap(input logic [1:0] s, input int n);
		apb(1'b1, 12'h000, {26'h0, 2'b11, s, 2'b01});
		apb(1'b1, 12'h000, {26'h0, 2'b10, s, 2'b01});
		edges(2 ** (n - 1) - 1);
		chk(tout, 1'b0, "tap low");
		edges(1);
		chk(tout, 1'b1, "tap high");
		apb(1'b0, 12'h008, 32'h0);
		chk(q, (s == 2'b10) ? 32'(2 ** (n - 1)) << pbt_pkg::LO_STAGES : 32'(2 ** (n - 1)), "count");
	endtask
	// Internal oscillator counts; forced init holds the chain cleared
	task automatic t_osc;
		apb(1'b1, 12'h000, 32'h09);
		repeat (20) @(posedge clk);
		apb(1'b0, 12'h008, 32'h0);
		chk(q[7:0], 8'h00, "osc low stages");
		chk(q[15:8] != 8'h00, 1'b1, "osc runs");
		apb(1'b1, 12'h000, 32'h19);
		repeat (20) @(posedge clk);
		apb(1'b0, 12'h008, 32'h0);
		chk(q, 32'h0, "osc held");
		apb(1'b0, 12'h004, 32'h0);
		chk(q, 32'h4, "osc status");
	endtask
	task automatic t_single;
		apb(1'b1, 12'h000, 32'h3a);
		edges(8);
		apb(1'b0, 12'h008, 32'h0);
		chk(q, 32'h0, "held");
		chk(tout, 1'b1, "pol");
		apb(1'b1, 12'h000, 32'h2a);
		edges(127);
		chk(tout, 1'b1, "before");
		edges(1);
		chk(tout, 1'b0, "flip");
		edges(256);
		chk(tout, 1'b0, "stay");
		apb(1'b1, 12'h000, 32'h2b);
		apb(1'b1, 12'h000, 32'h2a);
		repeat (2) @(negedge clk);
		chk(tout, 1'b1, "mode restart");
		edges(128);
		apb(1'b1, 12'h000, 32'h3a);
		repeat (2) @(negedge clk);
		chk(tout, 1'b1, "init restart");
	endtask
	task automatic t_por;
		apb(1'b1, 12'h000, 32'h29);
		edges(5);
		pulse(1'b0);
		apb(1'b0, 12'h008, 32'h0);
		chk(q, 32'h0, "por clear");
		edges(5);
		pulse(1'b1);
		apb(1'b0, 12'h008, 32'h0);
		chk(q, 32'h5 << pbt_pkg::LO_STAGES, "por off");
		apb(1'b1, 12'h000, 32'h39);
		apb(1'b0, 12'h008, 32'h0);
		chk(q, 32'h0, "init alone");
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_osc;
		t_tap(2'b00, 13);
		t_tap(2'b01, 10);
		t_tap(2'b10, 8);
		t_tap(2'b11, 16);
		t_single;
		t_por;
		close_out;
	end
	// Hang guard, above the roughly 76k cycles the scenarios need
	initial
	begin
		#760000;
		num_errors++;
		close_out;
	end
endmodule
bind pbt_timer pbt_timer_chk i_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce),
	.i_por_pulse(i_por_pulse), .i_power_on_init_off(i_power_on_init_off), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .o_timer_out(o_timer_out));
